//--- hdl/hvsp_map.vh
// Constants for the high-voltage serial programming sequencer.
`ifndef HVSP_MAP_VH
`define HVSP_MAP_VH

// Reference clock rate in MHz and timing figures in microseconds.
`define HVSP_CLK_MHZ 20
`define HVSP_LATCH_US 10
`define HVSP_RELEASE_US 10

// Serial frame layout: 11 clocks, payload in bits 9..2 of the capture.
`define HVSP_FRAME_LAST 4'ha
`define HVSP_PAY_MSB 9
`define HVSP_PAY_LSB 2

// Instruction-input byte codes.
`define HVSP_II_LOAD_CMD 8'h4c
`define HVSP_II_ADDR_LO 8'h0c
`define HVSP_II_ADDR_HI 8'h1c
`define HVSP_II_DATA_LO 8'h2c
`define HVSP_II_DATA_HI 8'h3c
`define HVSP_II_LATCH_FL 8'h7d
`define HVSP_II_LATCH_EE 8'h6d
`define HVSP_II_ARM 8'h64
`define HVSP_II_EXEC 8'h6c
`define HVSP_II_RD_LO 8'h68
`define HVSP_II_RD_HI 8'h78

// Command codes carried on the data input with the load-command code.
`define HVSP_CMD_NOP 8'h00
`define HVSP_CMD_ERASE 8'h80
`define HVSP_CMD_WR_FLASH 8'h10
`define HVSP_CMD_RD_FLASH 8'h02
`define HVSP_CMD_WR_EE 8'h11
`define HVSP_CMD_RD_EE 8'h03

// Operations issued to the nonvolatile array.
`define HVSP_OP_NONE 3'h0
`define HVSP_OP_RD_FLASH 3'h1
`define HVSP_OP_RD_EE 3'h2
`define HVSP_OP_PG_FLASH 3'h3
`define HVSP_OP_PG_EE 3'h4
`define HVSP_OP_ER_FLASH 3'h5
`define HVSP_OP_ER_EE 3'h6
`define HVSP_OP_ER_LOCK 3'h7

`endif

//--- hdl/hvsp_page_buf.v
// Page buffer that collects program data before a whole-page write.
`timescale 1ns/1ps
module hvsp_page_buf #(
    parameter WORDS = 32,
    parameter IDXW = 5
) (
    input wire clk,             // Reference clock.
    input wire wr_en,           // Write strobe.
    input wire [IDXW-1:0] wr_idx, // Write index.
    input wire [15:0] wr_data,  // Write word.
    input wire [IDXW-1:0] rd_idx, // Read index.
    output wire [15:0] rd_data  // Word at read index.
);
    reg [15:0] mem_r [0:WORDS-1];

    always @(posedge clk) begin
        if (wr_en) begin
            mem_r[wr_idx] <= wr_data;
        end
    end

    assign rd_data = mem_r[rd_idx];
endmodule

//--- hdl/hvsp_seq.v
// Device-side high-voltage serial programming sequencer.
// Function
// - Entry pins stay stable 10 us after high voltage; device latches them.
// - Programming mode ends when power goes or high voltage is removed.
// - Loaded command and address stay held across successive locations.
// - Chip erase clears flash, EEPROM and lock bits, never fuses.
// - Lock bits are cleared only after flash erase has completed.
// - EEPROM survives chip erase when the preserve fuse is programmed.
// - Data output rises when erase ends; programmer then loads no-op.
// - Flash data is latched in a page buffer, programmed as one page.
// - Data output rises when flash page programming finishes.
// - Data output rises when EEPROM page programming completes.
// - Inputs sampled and output presented on the serial clock rising edge.
// - Read-flash command shifts out the low then high byte of the word.
// - Read-EEPROM command shifts out the addressed byte.
`timescale 1ns/1ps
`include "hvsp_map.vh"
module hvsp_seq #(
    parameter PAGE_WORDS = 32,
    parameter IDXW = 5
) (
    input wire REF_CLK,              // 20 MHz reference clock.
    input wire RESET,                // Synchronous reset, power removal.
    input wire HV_PRESENT,           // Reset pin at programming voltage.
    input wire SERIAL_DATA_INPUT,    // Serial data pin, entry bit 0.
    input wire SERIAL_INSTRUCTION_INPUT, // Serial instruction, entry bit 1.
    input wire PROGRAMMING_SERIAL_CLOCK, // Serial clock pin.
    input wire SERIAL_DATA_OUTPUT_I, // Shared pin level, entry bit 2.
    output reg SERIAL_DATA_OUTPUT_O, // Shared pin drive value.
    output reg SERIAL_DATA_OUTPUT_OE, // Shared pin drive enable.
    output wire PROG_MODE,           // Programming mode active.
    input wire EEPROM_PRESERVE_FUSE, // Preserve fuse programmed, high.
    output reg NVM_START,            // One-cycle array operation start.
    output reg [2:0] NVM_OP,         // Array operation code.
    output reg [15:0] NVM_ADDR,      // Array word or byte address.
    output reg [15:0] NVM_WDATA,     // Array write data for byte writes.
    input wire NVM_BUSY,             // Array operation in progress.
    input wire [15:0] NVM_RDATA,     // Array read word.
    input wire [IDXW-1:0] NVM_BUF_IDX, // Page buffer index from array.
    output wire [15:0] NVM_BUF_DATA  // Page buffer word at that index.
);
    localparam integer LATCH_N = `HVSP_LATCH_US * `HVSP_CLK_MHZ;
    localparam integer RELEASE_N = `HVSP_RELEASE_US * `HVSP_CLK_MHZ;
    localparam [8:0] LATCH_CYC = LATCH_N[8:0];
    localparam [8:0] RELEASE_CYC = RELEASE_N[8:0];
    localparam [1:0] M_OFF = 2'h0;
    localparam [1:0] M_LATCH = 2'h1;
    localparam [1:0] M_RELEASE = 2'h2;
    localparam [1:0] M_ON = 2'h3;
    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_START = 2'h1;
    localparam [1:0] S_WAIT = 2'h2;
    reg hv_s1_r, hv_s2_r, sdi_s1_r, sdi_s2_r, sii_s1_r, sii_s2_r;
    reg sci_s1_r, sci_s2_r, sci_d_r, sdo_s1_r, sdo_s2_r;
    reg [1:0] mode_r, st_r;
    reg [8:0] tmr_r;
    reg [3:0] bit_r;
    reg [10:0] sdi_sh_r, sii_sh_r;
    reg [7:0] out_sh_r, cmd_r, addr_lo_r, addr_hi_r, data_lo_r, data_hi_r;
    reg [15:0] rd_word_r, buf_wd;
    reg [2:0] op_r;
    reg armed_r, rd_pend_r, buf_we;

    wire sci_rise = sci_s2_r & ~sci_d_r;
    wire frame_end = sci_rise && (mode_r == M_ON) &&
                     (bit_r == `HVSP_FRAME_LAST);
    wire [10:0] sdi_cap = {sdi_sh_r[9:0], sdi_s2_r};
    wire [10:0] sii_cap = {sii_sh_r[9:0], sii_s2_r};
    wire [7:0] din = sdi_cap[`HVSP_PAY_MSB:`HVSP_PAY_LSB];
    wire [7:0] iin = sii_cap[`HVSP_PAY_MSB:`HVSP_PAY_LSB];
    wire entry_pins_low = ~sdi_s2_r & ~sii_s2_r & ~sdo_s2_r;
    wire ready = (st_r == S_IDLE);

    assign PROG_MODE = (mode_r == M_ON);

    hvsp_page_buf #(
        .WORDS(PAGE_WORDS),
        .IDXW(IDXW)
    ) u_buf (
        .clk(REF_CLK),
        .wr_en(buf_we),
        .wr_idx(addr_lo_r[IDXW-1:0]),
        .wr_data(buf_wd),
        .rd_idx(NVM_BUF_IDX),
        .rd_data(NVM_BUF_DATA)
    );

    // Every pin level passes two flip-flops before use.
    always @(posedge REF_CLK) begin
        {hv_s2_r, hv_s1_r} <= {hv_s1_r, HV_PRESENT};
        {sdi_s2_r, sdi_s1_r} <= {sdi_s1_r, SERIAL_DATA_INPUT};
        {sii_s2_r, sii_s1_r} <= {sii_s1_r, SERIAL_INSTRUCTION_INPUT};
        sci_s1_r <= PROGRAMMING_SERIAL_CLOCK;
        sci_s2_r <= sci_s1_r;
        sci_d_r <= sci_s2_r;
        {sdo_s2_r, sdo_s1_r} <= {sdo_s1_r, SERIAL_DATA_OUTPUT_I};
    end

    // Mode entry: latch the select pattern, then wait for the pin release.
    always @(posedge REF_CLK) begin
        if (RESET || !hv_s2_r) begin
            mode_r <= M_OFF;
            tmr_r <= 9'h000;
        end else begin
            case (mode_r)
                M_OFF: begin
                    if (entry_pins_low) begin
                        mode_r <= M_LATCH;
                    end
                    tmr_r <= 9'h000;
                end
                M_LATCH: begin
                    if (!entry_pins_low) begin
                        mode_r <= M_OFF;
                        tmr_r <= 9'h000;
                    end else if (tmr_r == LATCH_CYC - 9'h001) begin
                        mode_r <= M_RELEASE;
                        tmr_r <= 9'h000;
                    end else begin
                        tmr_r <= tmr_r + 9'h001;
                    end
                end
                M_RELEASE: begin
                    if (tmr_r == RELEASE_CYC - 9'h001) begin
                        mode_r <= M_ON;
                    end else begin
                        tmr_r <= tmr_r + 9'h001;
                    end
                end
                M_ON: tmr_r <= 9'h000;
                default: mode_r <= M_OFF;
            endcase
        end
    end

    // Output pin: released until in mode, then low while busy, else data.
    always @(posedge REF_CLK) begin
        if (RESET) begin
            SERIAL_DATA_OUTPUT_OE <= 1'b0;
            SERIAL_DATA_OUTPUT_O <= 1'b0;
        end else begin
            SERIAL_DATA_OUTPUT_OE <= (mode_r == M_ON);
            SERIAL_DATA_OUTPUT_O <= ready & out_sh_r[7];
        end
    end

    // Serial framing: 11 rising edges per instruction.
    always @(posedge REF_CLK) begin
        if (RESET || mode_r != M_ON) begin
            bit_r <= 4'h0;
            sdi_sh_r <= 11'h000;
            sii_sh_r <= 11'h000;
        end else if (sci_rise) begin
            sdi_sh_r <= sdi_cap;
            sii_sh_r <= sii_cap;
            if (bit_r == `HVSP_FRAME_LAST) begin
                bit_r <= 4'h0;
            end else begin
                bit_r <= bit_r + 4'h1;
            end
        end
    end

    // Page buffer write data for flash words or EEPROM bytes.
    always @* begin
        buf_we = 1'b0;
        buf_wd = {data_hi_r, data_lo_r};
        if (frame_end && ready && iin == `HVSP_II_LATCH_FL &&
            cmd_r == `HVSP_CMD_WR_FLASH) begin
            buf_we = 1'b1;
        end else if (frame_end && ready && iin == `HVSP_II_LATCH_EE &&
                     cmd_r == `HVSP_CMD_WR_EE) begin
            buf_we = 1'b1;
            buf_wd = {8'h00, data_lo_r};
        end
    end

    // Command decode, held state and the array operation sequencer.
    always @(posedge REF_CLK) begin
        if (RESET || mode_r != M_ON) begin
            cmd_r <= `HVSP_CMD_NOP;
            {addr_lo_r, addr_hi_r, data_lo_r, data_hi_r} <= 32'h00000000;
            rd_word_r <= 16'h0000;
            armed_r <= 1'b0;
            st_r <= S_IDLE;
            op_r <= `HVSP_OP_NONE;
            rd_pend_r <= 1'b0;
            out_sh_r <= 8'hff;
            NVM_START <= 1'b0;
            NVM_OP <= `HVSP_OP_NONE;
            {NVM_ADDR, NVM_WDATA} <= 32'h00000000;
        end else begin
            NVM_START <= 1'b0;
            if (sci_rise && bit_r < 4'h8) begin
                out_sh_r <= {out_sh_r[6:0], 1'b1};
            end
            if (frame_end && ready) begin
                case (iin)
                    `HVSP_II_LOAD_CMD: begin
                        cmd_r <= din;
                        armed_r <= 1'b0;
                    end
                    `HVSP_II_ADDR_LO: addr_lo_r <= din;
                    `HVSP_II_ADDR_HI: addr_hi_r <= din;
                    `HVSP_II_DATA_LO: data_lo_r <= din;
                    `HVSP_II_DATA_HI: data_hi_r <= din;
                    `HVSP_II_ARM: armed_r <= 1'b1;
                    `HVSP_II_EXEC: begin
                        armed_r <= 1'b0;
                        if (armed_r && cmd_r == `HVSP_CMD_ERASE) begin
                            op_r <= `HVSP_OP_ER_FLASH;
                            st_r <= S_START;
                        end else if (armed_r &&
                                     cmd_r == `HVSP_CMD_WR_FLASH) begin
                            op_r <= `HVSP_OP_PG_FLASH;
                            st_r <= S_START;
                        end else if (cmd_r == `HVSP_CMD_WR_EE) begin
                            op_r <= `HVSP_OP_PG_EE;
                            st_r <= S_START;
                        end else if (armed_r &&
                                     cmd_r == `HVSP_CMD_RD_FLASH) begin
                            out_sh_r <= rd_word_r[7:0];
                        end
                    end
                    `HVSP_II_RD_LO: begin
                        armed_r <= 1'b1;
                        if (cmd_r == `HVSP_CMD_RD_FLASH) begin
                            op_r <= `HVSP_OP_RD_FLASH;
                            st_r <= S_START;
                            rd_pend_r <= 1'b1;
                        end else if (cmd_r == `HVSP_CMD_RD_EE) begin
                            op_r <= `HVSP_OP_RD_EE;
                            st_r <= S_START;
                            rd_pend_r <= 1'b1;
                        end
                    end
                    `HVSP_II_RD_HI: begin
                        if (cmd_r == `HVSP_CMD_RD_FLASH) begin
                            out_sh_r <= rd_word_r[15:8];
                        end
                    end
                    default: armed_r <= armed_r;
                endcase
            end else begin
                case (st_r)
                    S_START: begin
                        NVM_START <= 1'b1;
                        NVM_OP <= op_r;
                        NVM_ADDR <= {addr_hi_r, addr_lo_r};
                        NVM_WDATA <= {data_hi_r, data_lo_r};
                        st_r <= S_WAIT;
                    end
                    S_WAIT: begin
                        if (!NVM_BUSY && !NVM_START) begin
                            if (op_r == `HVSP_OP_ER_FLASH) begin
                                if (EEPROM_PRESERVE_FUSE) begin
                                    op_r <= `HVSP_OP_ER_LOCK;
                                end else begin
                                    op_r <= `HVSP_OP_ER_EE;
                                end
                                st_r <= S_START;
                            end else if (op_r == `HVSP_OP_ER_EE) begin
                                op_r <= `HVSP_OP_ER_LOCK;
                                st_r <= S_START;
                            end else begin
                                st_r <= S_IDLE;
                                op_r <= `HVSP_OP_NONE;
                                if (rd_pend_r) begin
                                    rd_word_r <= NVM_RDATA;
                                    rd_pend_r <= 1'b0;
                                    if (cmd_r == `HVSP_CMD_RD_EE) begin
                                        out_sh_r <= NVM_RDATA[7:0];
                                    end
                                end
                            end
                        end
                    end
                    default: st_r <= S_IDLE;
                endcase
            end
        end
    end
endmodule

//--- testbench/hvsp_seq_chk.sv
// Port checker for the serial programming sequencer.
`timescale 1ns/1ps
module hvsp_seq_chk (
    input wire REF_CLK, // Clock.
    input wire RESET, // Reset.
    input wire HV_PRESENT, // High voltage seen.
    input wire SERIAL_DATA_OUTPUT_O, // Pin value.
    input wire SERIAL_DATA_OUTPUT_OE, // Pin enable.
    input wire PROG_MODE, // Mode flag.
    input wire EEPROM_PRESERVE_FUSE, // Preserve fuse.
    input wire NVM_START, // Start pulse.
    input wire [2:0] NVM_OP, // Operation.
    input wire NVM_BUSY // Array busy.
);
    reg [9:0] hv_cnt_r;
    reg er_seen_r;
    // Counts how long high voltage has been present, saturating.
    always @(posedge REF_CLK) begin
        if (RESET || !HV_PRESENT)
            hv_cnt_r <= 10'h000;
        else if (hv_cnt_r != 10'h3ff)
            hv_cnt_r <= hv_cnt_r + 10'h001;
        if (RESET || (NVM_START && NVM_OP == 3'h7))
            er_seen_r <= 1'b0;
        else if (NVM_START && NVM_OP == 3'h5)
            er_seen_r <= 1'b1;
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    property p_oe;
        SERIAL_DATA_OUTPUT_OE |-> $past(PROG_MODE);
    endproperty
    a_oe: assert property (p_oe) else $error("driven off mode");
    property p_entry;
        $rose(PROG_MODE) |-> hv_cnt_r >= 10'h0c8;
    endproperty
    a_entry: assert property (p_entry) else $error("early entry");
    property p_exit;
        $fell(HV_PRESENT) |-> ##[1:5] !PROG_MODE;
    endproperty
    a_exit: assert property (p_exit) else $error("mode kept");
    property p_hold;
        PROG_MODE && HV_PRESENT |=> PROG_MODE;
    endproperty
    a_hold: assert property (p_hold) else $error("mode lost");
    property p_busy;
        NVM_BUSY |=> !SERIAL_DATA_OUTPUT_O;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not low");
    property p_lock;
        NVM_START && NVM_OP == 3'h7 |-> er_seen_r && !NVM_BUSY;
    endproperty
    a_lock: assert property (p_lock) else $error("lock early");
    property p_fuse;
        NVM_START && EEPROM_PRESERVE_FUSE |-> NVM_OP != 3'h6;
    endproperty
    a_fuse: assert property (p_fuse) else $error("eeprom erased");
    property p_pulse;
        NVM_START |-> PROG_MODE ##1 !NVM_START;
    endproperty
    a_pulse: assert property (p_pulse) else $error("bad start");
endmodule

//--- testbench/hvsp_prog_model.sv
// Programmer model that shifts serial frames into the sequencer.
`timescale 1ns/1ps
module hvsp_prog_model (
    input wire clk, // Reference clock.
    input wire sdo_pin, // Resolved shared pin level.
    output reg programming_serial_clock, // Serial clock, low between frames.
    output reg serial_data_input, // Serial data.
    output reg serial_instruction_input // Serial instruction.
);
    initial begin
        programming_serial_clock = 1'b0;
        serial_data_input = 1'b0;
        serial_instruction_input = 1'b0;
    end
    // Start bit, eight payload bits, two zeros; period of 400 ns.
    task frame(input [7:0] d, input [7:0] ins, output [7:0] q);
        integer i;
        reg [10:0] fd;
        reg [10:0] fi;
        begin
            fd = {1'b0, d, 2'b00};
            fi = {1'b0, ins, 2'b00};
            q = 8'h00;
            for (i = 10; i >= 0; i = i - 1) begin
                @(posedge clk);
                programming_serial_clock <= 1'b0;
                serial_data_input <= fd[i];
                serial_instruction_input <= fi[i];
                repeat (4) @(posedge clk);
                if (i > 2)
                    q = {q[6:0], sdo_pin};
                programming_serial_clock <= 1'b1;
                repeat (3) @(posedge clk);
            end
            @(posedge clk);
            programming_serial_clock <= 1'b0;
        end
    endtask
endmodule

//--- testbench/tb_top.sv
// Bench for the serial programming sequencer.
`timescale 1ns/1ps
module tb_top;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg hv = 1'b0;
    reg drv = 1'b1;
    reg fuse = 1'b0;
    reg busy = 1'b0;
    reg last = 1'b0;
    reg [4:0] bidx = 5'h00;
    reg [15:0] oaddr = 16'h0000;
    reg [7:0] rq;
    reg [2:0] ops [0:15];
    integer nops = 0;
    integer bcnt = 0;
    integer errors = 0;
    integer total_checks = 0;
    wire programming_serial_clock, serial_data_input, serial_instruction_input, oe, o, mode, start;
    wire [2:0] op;
    wire [15:0] addr, wdata, bdata;
    wire pin = oe ? o : (drv ? 1'b0 : ~last);
    always #25 clk = ~clk;
    // Array model: busy for 24 cycles, read word is address xor a key.
    always @(posedge clk) begin
        last <= pin;
        if (start) begin
            busy <= 1'b1;
            bcnt <= 24;
            oaddr <= addr;
            ops[nops] <= op;
            nops <= nops + 1;
        end else if (bcnt != 0) begin
            bcnt <= bcnt - 1;
            busy <= bcnt != 1;
        end
    end
    hvsp_seq u_dut (.REF_CLK(clk), .RESET(rst), .HV_PRESENT(hv),
        .SERIAL_DATA_INPUT(serial_data_input), .SERIAL_INSTRUCTION_INPUT(serial_instruction_input),
        .PROGRAMMING_SERIAL_CLOCK(programming_serial_clock), .SERIAL_DATA_OUTPUT_I(pin),
        .SERIAL_DATA_OUTPUT_O(o), .SERIAL_DATA_OUTPUT_OE(oe),
        .PROG_MODE(mode), .EEPROM_PRESERVE_FUSE(fuse), .NVM_START(start),
        .NVM_OP(op), .NVM_ADDR(addr), .NVM_WDATA(wdata), .NVM_BUSY(busy),
        .NVM_RDATA(oaddr ^ 16'h5a3c), .NVM_BUF_IDX(bidx),
        .NVM_BUF_DATA(bdata));
    hvsp_prog_model u_prog (.clk(clk), .sdo_pin(pin), .programming_serial_clock(programming_serial_clock),
        .serial_data_input(serial_data_input), .serial_instruction_input(serial_instruction_input));
    task chk(input [15:0] got, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", total_checks, errors);
            if (errors == 0 && total_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task fr(input [7:0] d, input [7:0] i);
        u_prog.frame(d, i, rq);
    endtask
    task wait_rdy;
        integer n;
        begin
            repeat (8) @(posedge clk);
            chk({15'h0000, pin}, 16'h0000);
            for (n = 0; n < 200 && pin !== 1'b1; n = n + 1)
                @(posedge clk);
            chk({15'h0000, pin}, 16'h0001);
        end
    endtask
    task t_entry;
        begin
            repeat (400) @(posedge clk);
            hv <= 1'b1;
            repeat (250) @(posedge clk);
            chk({14'h0000, mode, oe}, 16'h0000);
            drv <= 1'b0;
            repeat (6000) @(posedge clk);
            chk({13'h0000, mode, oe, pin}, 16'h0007);
            $display("entry done");
        end
    endtask
    task t_erase(input f);
        integer b;
        begin
            fuse <= f;
            b = nops;
            fr(8'h80, 8'h4c);
            fr(8'h00, 8'h64);
            fr(8'h00, 8'h6c);
            wait_rdy;
            chk(nops[15:0] - b[15:0], f ? 16'h0002 : 16'h0003);
            chk({13'h0000, ops[b]}, 16'h0005);
            chk({13'h0000, ops[b + 1]}, f ? 16'h0007 : 16'h0006);
            chk({13'h0000, ops[nops - 1]}, 16'h0007);
            fr(8'h00, 8'h4c);
            $display("erase done");
        end
    endtask
    task t_prog;
        integer b;
        begin
            fr(8'h10, 8'h4c);
            fr(8'h03, 8'h0c);
            fr(8'ha5, 8'h2c);
            fr(8'h5c, 8'h3c);
            fr(8'h00, 8'h7d);
            fr(8'h01, 8'h1c);
            b = nops;
            fr(8'h00, 8'h64);
            fr(8'h00, 8'h6c);
            bidx <= 5'h03;
            repeat (4) @(posedge clk);
            chk(bdata, 16'h5ca5);
            chk(addr, 16'h0103);
            chk({13'h0000, ops[b]}, 16'h0003);
            wait_rdy;
            fr(8'h00, 8'h4c);
            fr(8'h11, 8'h4c);
            fr(8'h07, 8'h0c);
            fr(8'h00, 8'h1c);
            fr(8'hc3, 8'h2c);
            fr(8'h00, 8'h6d);
            b = nops;
            fr(8'h00, 8'h6c);
            repeat (4) @(posedge clk);
            chk({addr[7:0], wdata[7:0]}, 16'h07c3);
            chk({13'h0000, ops[b]}, 16'h0004);
            wait_rdy;
            fr(8'h00, 8'h4c);
            $display("program done");
        end
    endtask
    task t_read;
        begin
            fr(8'h02, 8'h4c);
            fr(8'h03, 8'h0c);
            fr(8'h01, 8'h1c);
            fr(8'h00, 8'h68);
            repeat (40) @(posedge clk);
            fr(8'h00, 8'h6c);
            fr(8'h00, 8'h78);
            chk({8'h00, rq}, 16'h003f);
            repeat (40) @(posedge clk);
            fr(8'h00, 8'h7c);
            chk({8'h00, rq}, 16'h005b);
            fr(8'h03, 8'h4c);
            fr(8'h07, 8'h0c);
            fr(8'h00, 8'h1c);
            fr(8'h00, 8'h68);
            repeat (40) @(posedge clk);
            fr(8'h00, 8'h6c);
            chk({8'h00, rq}, 16'h003b);
            hv <= 1'b0;
            repeat (8) @(posedge clk);
            chk({14'h0000, mode, oe}, 16'h0000);
            $display("read and exit done");
        end
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_entry;
        t_erase(1'b0);
        t_erase(1'b1);
        t_prog;
        t_read;
        summarize;
    end
    initial begin
        repeat (40000) @(posedge clk);
        errors = errors + 1;
        $display("MISMATCH %0t watchdog expired", $time);
        summarize;
    end
endmodule
bind hvsp_seq hvsp_seq_chk u_chk (.REF_CLK(REF_CLK), .RESET(RESET),
    .HV_PRESENT(HV_PRESENT), .SERIAL_DATA_OUTPUT_O(SERIAL_DATA_OUTPUT_O),
    .SERIAL_DATA_OUTPUT_OE(SERIAL_DATA_OUTPUT_OE), .PROG_MODE(PROG_MODE),
    .EEPROM_PRESERVE_FUSE(EEPROM_PRESERVE_FUSE), .NVM_START(NVM_START),
    .NVM_OP(NVM_OP), .NVM_BUSY(NVM_BUSY));
